// File: uir_usb_interface_block.sv
// usb interface block: register port, utmi+ controls and packet capture
// Functional notes
// - bits 4:2 drive opmode, reset one
// - bit 1 drives termselect, reset one
// - bit 0 drives xcvrselect, reset one
// - otg bits 7,6 external vbus select/drive
// - otg bits 4:0 vbus and pull controls
// - otg flags read live transceiver status
// - serial bits 6:4 read rx lines
// - serial bits 3,2 drive se0, data
// - serial bit 1 drives tx enable_n
// - serial bit 0 selects fs/ls serial
// - normal flags 6 and 2 clear at next packet
// - flag 6 on good matching token
// - flags 5:3 show se0, k, j
// - flag 2 on crc16 failure
// - flags 1,0 follow rx active/error
// - sticky flags hold until written one
// - four masks drive four flag ports
// - eleven-bit writable frame number, loaded from start-of-frame
// - last pid captured, reads zero after reset
// - last endpoint with valid bit 4
// - marked endpoint delivered ored with 0x10
// - only tokens for our address pass
`default_nettype none
module uir_usb_interface_block
   import uir_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // peripheral register port
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   output logic      [31:0] regRdData,
   output logic             regRdValid,
   // utmi+ mode controls
   output logic      [2:0]  opMode,
   output logic             termSelect,
   output logic             xcvrSelect,
   // on-the-go controls
   output logic             externalVbusIndicator,
   output logic             externalVbusDrive,
   output logic             chrgVbus,
   output logic             dischrgVbus,
   output logic             dmPulldown,
   output logic             dpPulldown,
   output logic             idLinePullup,
   // on-the-go status from the transceiver
   input  wire logic        bSessValid,
   input  wire logic        idGround,
   input  wire logic        hostDisconnect,
   input  wire logic        vbusValid,
   input  wire logic        sessValid,
   input  wire logic        sessEnd,
   // serial line controls and states
   output logic             txSe0,
   output logic             txData,
   output logic             txEnable_n,
   output logic             fsLsSerial,
   input  wire logic        rxDiff,
   input  wire logic        rxDm,
   input  wire logic        rxDp,
   // receive status from the transceiver
   input  wire logic [1:0]  lineState,
   input  wire logic        rxActive,
   input  wire logic        rxError,
   // decoded packet events
   input  wire logic        rxPktStart,
   input  wire logic        rxPidValid,
   input  wire logic [3:0]  rxPid,
   input  wire logic        rxTokenValid,
   input  wire logic [6:0]  rxTokenAddr,
   input  wire logic [3:0]  rxTokenEndp,
   input  wire logic        rxCrc5Ok,
   input  wire logic        rxPidOk,
   input  wire logic        rxCrc16Fail,
   input  wire logic        rxFrameValid,
   input  wire logic [10:0] rxFrameNum,
   // endpoint delivered toward the receive port
   output logic      [4:0]  rxEndpoint,
   output logic             rxEndpointValid,
   // masked flag ports
   output logic             flagOutPortA,
   output logic             flagOutPortB,
   output logic             flagOutPortC,
   output logic             flagOutPortD
);
   typedef struct packed {
      logic [6:0]  devAddr;
      logic [4:0]  funcCtrl;
      logic [7:0]  otgCtrl;
      logic [3:0]  serialCtrl;
      logic [6:0]  sticky;
      logic [31:0] masks;
      logic [10:0] frame;
      logic [3:0]  lastPid;
      logic [3:0]  lastEp;
      logic        lastEpValid;
      logic [15:0] epMark;
      logic [31:0] otgMask;
      logic [31:0] rdData;
      logic        rdValid;
      logic [4:0]  rxEp;
      logic        rxEpValid;
      logic        tokenHit;
      logic        softRst;
   } uir_top_state_t;

   localparam uir_top_state_t TOP_RESET = '{
      funcCtrl   : FUNC_CTRL_RESET,
      serialCtrl : SERIAL_RESET,
      default    : '0
   };

   uir_top_state_t s_reg;
   uir_top_state_t s_next;
   logic           tokenAccept;
   logic           softWrite;

   uir_flag_if flagBus ();

   // flag storage and the masked port outputs
   uir_flag_unit flagUnit (
      .clk     (clk),
      .sys_rst (sys_rst),
      .bus     (flagBus)
   );

   // a token counts only when checks pass and it is for us
   assign tokenAccept = rxTokenValid && rxCrc5Ok && rxPidOk
                        && (rxTokenAddr == s_reg.devAddr);
   assign softWrite   = regWrite && (regAddr == ADDR_SOFT_RESET);

   // feed the flag unit; flag writes are write-one-to-clear
   assign flagBus.sticky    = s_reg.sticky;
   assign flagBus.masks     = s_reg.masks;
   assign flagBus.clrWr     = regWrite && (regAddr == ADDR_LINE_FLAGS);
   assign flagBus.clrData   = regWrData[6:0];
   assign flagBus.pktStart  = rxPktStart;
   assign flagBus.tokenHit  = s_reg.tokenHit;
   assign flagBus.crcFail   = rxCrc16Fail;
   assign flagBus.lineState = lineState;
   assign flagBus.rxActive  = rxActive;
   assign flagBus.rxError   = rxError;
   assign flagBus.softRst   = s_reg.softRst;

   // next-state logic for registers and packet capture
   always_comb begin
      s_next           = s_reg;
      s_next.rdValid   = 1'b0;
      s_next.rxEpValid = 1'b0;
      s_next.tokenHit  = 1'b0;
      s_next.softRst   = 1'b0;

      // software writes; only defined bits are stored, except the port masks and the otg mask keep all 32 bits
      if (regWrite) begin
         case (regAddr)
            ADDR_DEV_ADDR: begin
               s_next.devAddr = regWrData[6:0];
            end
            ADDR_FUNC_CTRL: begin
               s_next.funcCtrl = regWrData[4:0];
            end
            ADDR_OTG_CTRL: begin
               s_next.otgCtrl = regWrData[7:0];
               s_next.otgCtrl[OTG_RSVD_BIT] = 1'b0;
            end
            ADDR_SERIAL: begin
               s_next.serialCtrl = regWrData[3:0];
            end
            ADDR_STICKY: begin
               s_next.sticky = regWrData[6:0];
            end
            ADDR_PORT_MASKS: begin
               s_next.masks = regWrData;
            end
            ADDR_FRAME: begin
               s_next.frame = regWrData[10:0];
            end
            ADDR_EP_MARK: begin
               s_next.epMark = regWrData[15:0];
            end
            ADDR_OTG_MASK: begin
               s_next.otgMask = regWrData;
            end
            default: begin
               s_next.otgMask = s_reg.otgMask;
            end
         endcase
      end

      // hardware frame number wins over a software write
      if (rxFrameValid) begin
         s_next.frame = rxFrameNum;
      end

      // non-token pids (data, handshake) are captured directly
      if (rxPidValid && (rxPid[1:0] != PID_TOKEN_TAG)) begin
         s_next.lastPid = rxPid;
      end

      // accepted token: pid, endpoint, mark and flag event
      if (tokenAccept) begin
         s_next.tokenHit    = 1'b1;
         s_next.lastPid     = rxPid;
         s_next.lastEp      = rxTokenEndp;
         s_next.lastEpValid = 1'b1;
         s_next.rxEpValid   = 1'b1;
         s_next.rxEp        = {1'b0, rxTokenEndp};
         if (s_reg.epMark[rxTokenEndp]) begin
            s_next.rxEp = {1'b0, rxTokenEndp} | EP_MARK_BIT;
         end
      end

      // register reads answer one cycle later
      if (regRead) begin
         s_next.rdValid = 1'b1;
         case (regAddr)
            ADDR_DEV_ADDR: begin
               s_next.rdData = 32'(s_reg.devAddr);
            end
            ADDR_FUNC_CTRL: begin
               s_next.rdData = 32'(s_reg.funcCtrl);
            end
            ADDR_OTG_CTRL: begin
               s_next.rdData = 32'(s_reg.otgCtrl);
            end
            ADDR_OTG_FLAGS: begin
               s_next.rdData = 32'({bSessValid, idGround, hostDisconnect,
                                    vbusValid, sessValid, sessEnd});
            end
            ADDR_SERIAL: begin
               s_next.rdData = 32'({rxDiff, rxDm, rxDp, s_reg.serialCtrl});
            end
            ADDR_LINE_FLAGS: begin
               s_next.rdData = 32'(flagBus.flags);
            end
            ADDR_STICKY: begin
               s_next.rdData = 32'(s_reg.sticky);
            end
            ADDR_PORT_MASKS: begin
               s_next.rdData = s_reg.masks;
            end
            ADDR_FRAME: begin
               s_next.rdData = 32'(s_reg.frame);
            end
            ADDR_LAST_PID: begin
               s_next.rdData = 32'(s_reg.lastPid);
            end
            ADDR_LAST_EP: begin
               s_next.rdData = 32'({s_reg.lastEpValid, s_reg.lastEp});
            end
            ADDR_EP_MARK: begin
               s_next.rdData = 32'(s_reg.epMark);
            end
            ADDR_OTG_MASK: begin
               s_next.rdData = s_reg.otgMask;
            end
            default: begin
               s_next.rdData = 32'h0000_0000;
            end
         endcase
      end

      // any write to the reset word returns all block state to reset;
      // the flag unit follows one cycle later via softRst
      if (softWrite) begin
         s_next         = TOP_RESET;
         s_next.softRst = 1'b1;
      end
   end

   // single state register; async reset loads constants only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= TOP_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // register port answer
   assign regRdData  = s_reg.rdData;
   assign regRdValid = s_reg.rdValid;

   // utmi+ mode controls come straight from stored bits
   assign opMode     = s_reg.funcCtrl[4:2];
   assign termSelect = s_reg.funcCtrl[1];
   assign xcvrSelect = s_reg.funcCtrl[0];

   // on-the-go controls; bit 5 is reserved and unused
   assign externalVbusIndicator = s_reg.otgCtrl[7];
   assign externalVbusDrive     = s_reg.otgCtrl[6];
   assign chrgVbus              = s_reg.otgCtrl[4];
   assign dischrgVbus           = s_reg.otgCtrl[3];
   assign dmPulldown            = s_reg.otgCtrl[2];
   assign dpPulldown            = s_reg.otgCtrl[1];
   assign idLinePullup          = s_reg.otgCtrl[0];

   // serial line controls; tx enable idles high (off)
   assign txSe0      = s_reg.serialCtrl[3];
   assign txData     = s_reg.serialCtrl[2];
   assign txEnable_n = s_reg.serialCtrl[1];
   assign fsLsSerial = s_reg.serialCtrl[0];

   // endpoint toward the receive port, one-cycle strobe
   assign rxEndpoint      = s_reg.rxEp;
   assign rxEndpointValid = s_reg.rxEpValid;

   // flag ports are registered inside the flag unit
   assign flagOutPortA = flagBus.ports[0];
   assign flagOutPortB = flagBus.ports[1];
   assign flagOutPortC = flagBus.ports[2];
   assign flagOutPortD = flagBus.ports[3];
endmodule
`default_nettype wire

// File: uir_pkg.sv
// constants shared by the usb interface block and its flag unit
`default_nettype none
package uir_pkg;
   // register offsets on the peripheral port
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
   localparam logic [7:0] ADDR_DEV_ADDR   = 8'h08;
   localparam logic [7:0] ADDR_FUNC_CTRL  = 8'h0c;
   localparam logic [7:0] ADDR_OTG_CTRL   = 8'h10;
   localparam logic [7:0] ADDR_OTG_FLAGS  = 8'h14;
   localparam logic [7:0] ADDR_SERIAL     = 8'h18;
   localparam logic [7:0] ADDR_LINE_FLAGS = 8'h1c;
   localparam logic [7:0] ADDR_STICKY     = 8'h20;
   localparam logic [7:0] ADDR_PORT_MASKS = 8'h24;
   localparam logic [7:0] ADDR_FRAME      = 8'h28;
   localparam logic [7:0] ADDR_LAST_PID   = 8'h2c;
   localparam logic [7:0] ADDR_LAST_EP    = 8'h30;
   localparam logic [7:0] ADDR_EP_MARK    = 8'h34;
   localparam logic [7:0] ADDR_OTG_MASK   = 8'h38;
   // field layout and values after reset
   localparam logic [4:0] FUNC_CTRL_RESET = 5'h07;
   localparam logic [3:0] SERIAL_RESET    = 4'h2;
   localparam int         OTG_RSVD_BIT    = 5;
   localparam int         MASK_STRIDE     = 8;
   localparam int         FLAG_COUNT      = 7;
   localparam int         PORT_COUNT      = 4;
   // signal flag positions
   localparam int         FLAG_TOKEN      = 6;
   localparam int         FLAG_SE0        = 5;
   localparam int         FLAG_K          = 4;
   localparam int         FLAG_J          = 3;
   localparam int         FLAG_CRC16      = 2;
   localparam int         FLAG_RXACT      = 1;
   localparam int         FLAG_RXERR      = 0;
   // bits that follow a live level when not sticky
   localparam logic [6:0] FLAG_LEVELS     = 7'h3b;
   // utmi+ linestate codes
   localparam logic [1:0] LINE_SE0        = 2'h0;
   localparam logic [1:0] LINE_J          = 2'h1;
   localparam logic [1:0] LINE_K          = 2'h2;
   // low pid bits shared by all token pids
   localparam logic [1:0] PID_TOKEN_TAG   = 2'h1;
   // mark added to a special endpoint number
   localparam logic [4:0] EP_MARK_BIT     = 5'h10;
endpackage
`default_nettype wire

// File: uir_flag_if.sv
// signals between the register block and the flag unit
`default_nettype none
interface uir_flag_if;
   logic [6:0]  sticky;
   logic [31:0] masks;
   logic        clrWr;
   logic [6:0]  clrData;
   logic        pktStart;
   logic        tokenHit;
   logic        crcFail;
   logic [1:0]  lineState;
   logic        rxActive;
   logic        rxError;
   logic        softRst;
   logic [6:0]  flags;
   logic [3:0]  ports;
   modport ctrl (output sticky, masks, clrWr, clrData, pktStart, tokenHit, crcFail,
                 lineState, rxActive, rxError, softRst, input flags, ports);
   modport unit (input sticky, masks, clrWr, clrData, pktStart, tokenHit, crcFail,
                 lineState, rxActive, rxError, softRst, output flags, ports);
endinterface
`default_nettype wire

// File: uir_flag_unit.sv
// line and error flags with stickiness and the four masked flag ports
`default_nettype none
module uir_flag_unit
   import uir_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link to the register block
   uir_flag_if.unit bus
);
   typedef struct packed {
      logic [6:0] flags;
      logic [3:0] ports;
   } uir_flag_state_t;

   uir_flag_state_t s_reg;
   uir_flag_state_t s_next;
   logic [6:0]      events;

   // raw causes of each flag, in flag order
   always_comb begin
      events              = '0;
      events[FLAG_TOKEN]  = bus.tokenHit;
      events[FLAG_SE0]    = bus.lineState == LINE_SE0;
      events[FLAG_K]      = bus.lineState == LINE_K;
      events[FLAG_J]      = bus.lineState == LINE_J;
      events[FLAG_CRC16]  = bus.crcFail;
      events[FLAG_RXACT]  = bus.rxActive;
      events[FLAG_RXERR]  = bus.rxError;
   end

   // per-flag update; a set beats a clear in the same cycle, and a soft reset beats both
   always_comb begin
      s_next = s_reg;
      for (int i = 0; i < FLAG_COUNT; i++) begin
         if (bus.sticky[i]) begin
            if (bus.clrWr && bus.clrData[i]) begin
               s_next.flags[i] = 1'b0;
            end
            if (events[i]) begin
               s_next.flags[i] = 1'b1;
            end
         end else begin
            if (bus.pktStart || (bus.clrWr && bus.clrData[i])) begin
               s_next.flags[i] = 1'b0;
            end
            if (FLAG_LEVELS[i]) begin
               s_next.flags[i] = events[i];
            end else if (events[i]) begin
               s_next.flags[i] = 1'b1;
            end
         end
      end
      for (int j = 0; j < PORT_COUNT; j++) begin
         s_next.ports[j] = |(s_next.flags & bus.masks[j*MASK_STRIDE +: FLAG_COUNT]);
      end
      if (bus.softRst) begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.flags = s_reg.flags;
   assign bus.ports = s_reg.ports;
endmodule
`default_nettype wire

// File: uir_usb_props.sv
// concurrent checks on the usb interface block ports
`default_nettype none
module uir_usb_props
   import uir_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // register port
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic [31:0] regRdData,
   input wire logic        regRdValid,
   // controls and line levels
   input wire logic [2:0]  opMode,
   input wire logic        xcvrSelect,
   input wire logic        txEnable_n,
   input wire logic        idLinePullup,
   input wire logic        rxDiff,
   input wire logic        rxDm,
   input wire logic        rxDp,
   // packets and flag port
   input wire logic        rxTokenValid,
   input wire logic        rxCrc5Ok,
   input wire logic        rxPidOk,
   input wire logic [4:0]  rxEndpoint,
   input wire logic        rxEndpointValid,
   input wire logic        flagOutPortA
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // writes land in the controls one edge after the strobe
   property p_opmode; regWrite && regAddr == ADDR_FUNC_CTRL |=> opMode == $past(regWrData[4:2]); endproperty
   a_opmode: assert property (p_opmode) else $error("opmode not taken from write");
   property p_xcvr; regWrite && regAddr == ADDR_FUNC_CTRL |=> xcvrSelect == $past(regWrData[0]); endproperty
   a_xcvr: assert property (p_xcvr) else $error("xcvr select not taken from write");
   property p_idpu; regWrite && regAddr == ADDR_OTG_CTRL |=> idLinePullup == $past(regWrData[0]); endproperty
   a_idpu: assert property (p_idpu) else $error("id pullup not taken from write");
   property p_txen; regWrite && regAddr == ADDR_SERIAL |=> txEnable_n == $past(regWrData[1]); endproperty
   a_txen: assert property (p_txen) else $error("tx enable not taken from write");
   // reads answer after one edge, never unasked
   property p_rdvalid; regRdValid |-> $past(regRead); endproperty
   a_rdvalid: assert property (p_rdvalid) else $error("read answer without request");
   property p_serrd; regRead && regAddr == ADDR_SERIAL |=> regRdValid && regRdData[6:4] == $past({rxDiff, rxDm, rxDp});
   endproperty
   a_serrd: assert property (p_serrd) else $error("line levels misread");
   property p_rsvd; regRead && regAddr == ADDR_FUNC_CTRL |=> regRdData[31:5] == 27'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
   // only good tokens reach the receive port
   property p_badtok; rxTokenValid && !(rxCrc5Ok && rxPidOk) |=> !rxEndpointValid; endproperty
   a_badtok: assert property (p_badtok) else $error("failed token delivered");
   property p_epcause; rxEndpointValid |-> $past(rxTokenValid && rxCrc5Ok && rxPidOk); endproperty
   a_epcause: assert property (p_epcause) else $error("endpoint pulse without good token");
   c_read: cover property (regRdValid);
   c_mark: cover property (rxEndpointValid && rxEndpoint[4]);
   c_port: cover property (flagOutPortA);
endmodule
bind uir_usb_interface_block uir_usb_props u_props (.clk(clk), .sys_rst(sys_rst), .regWrite(regWrite),
   .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
   .opMode(opMode), .xcvrSelect(xcvrSelect), .txEnable_n(txEnable_n), .idLinePullup(idLinePullup),
   .rxDiff(rxDiff), .rxDm(rxDm), .rxDp(rxDp), .rxTokenValid(rxTokenValid), .rxCrc5Ok(rxCrc5Ok),
   .rxPidOk(rxPidOk), .rxEndpoint(rxEndpoint), .rxEndpointValid(rxEndpointValid), .flagOutPortA(flagOutPortA));
`default_nettype wire

// File: uir_xcvr_model.sv
// behavioural transceiver and packet decoder feeding the block
`default_nettype none
module uir_xcvr_model (
   // clock
   input  wire logic        clk,
   // status and line levels
   output logic      [5:0]  otgSt,
   output logic      [2:0]  lines,
   output logic      [1:0]  lineState,
   output logic             rxActive,
   output logic             rxError,
   // decoded packet events
   output logic             pktStart,
   output logic             crc16Fail,
   output logic             frmValid,
   output logic      [10:0] frmNum,
   output logic             tokValid,
   output logic      [3:0]  pid,
   output logic      [6:0]  tokAddr,
   output logic      [3:0]  tokEndp,
   output logic             tokGood
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus: no line state decoded, no events
   initial begin
      {otgSt, lines, lineState, rxActive, rxError} = {9'h000, 2'h3, 2'h0};
      {pktStart, crc16Fail, frmValid, tokValid, tokGood, frmNum, pid, tokAddr, tokEndp} = 31'h0;
   end
   // levels change just after an edge
   task automatic set_st(input logic [5:0] s, input logic [2:0] l, input logic [1:0] ls, input logic a, e);
      @(posedge clk);
      otgSt <= s;
      lines <= l;
      lineState <= ls;
      rxActive <= a;
      rxError <= e;
   endtask
   // fields go stale after the pulse so nothing may lean on them
   task automatic token(input logic [3:0] p, input logic [6:0] a, input logic [3:0] ep, input logic g);
      @(posedge clk);
      {tokValid, pid, tokAddr, tokEndp, tokGood} <= {1'b1, p, a, ep, g};
      @(posedge clk);
      {tokValid, pid, tokAddr, tokEndp, tokGood} <= {1'b0, ~p, ~a, ~ep, ~g};
   endtask
   // one-cycle packet start (its pid from n), crc failure or frame load
   task automatic pulse(input logic [2:0] k, input logic [10:0] n);
      @(posedge clk);
      {pktStart, crc16Fail, frmValid} <= k;
      {frmNum, pid} <= {n, n[3:0]};
      @(posedge clk);
      {pktStart, crc16Fail, frmValid} <= 3'h0;
      {frmNum, pid} <= {~n, ~n[3:0]};
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the usb interface block
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
   import uir_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, sys_rst, regWrite, regRead, regRdValid, rxEpValid;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData;
   logic [2:0]  opMode, lines;
   logic [1:0]  modeBits, lineState;
   logic [3:0]  serOut, ports, pid, tokEndp;
   logic [6:0]  otgOut, tokAddr;
   logic [5:0]  otgSt;
   logic [4:0]  rxEp;
   logic [10:0] frmNum;
   logic        rxActive, rxError, pktStart, crc16Fail, frmValid, tokValid, tokGood;
   int          err_total = 0, check_count = 0;
   uir_usb_interface_block DUT (.clk(clk), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .opMode(opMode), .termSelect(modeBits[1]), .xcvrSelect(modeBits[0]),
      .externalVbusIndicator(otgOut[6]), .externalVbusDrive(otgOut[5]), .chrgVbus(otgOut[4]),
      .dischrgVbus(otgOut[3]), .dmPulldown(otgOut[2]), .dpPulldown(otgOut[1]), .idLinePullup(otgOut[0]),
      .bSessValid(otgSt[5]), .idGround(otgSt[4]), .hostDisconnect(otgSt[3]), .vbusValid(otgSt[2]),
      .sessValid(otgSt[1]), .sessEnd(otgSt[0]), .txSe0(serOut[3]), .txData(serOut[2]),
      .txEnable_n(serOut[1]), .fsLsSerial(serOut[0]), .rxDiff(lines[2]), .rxDm(lines[1]), .rxDp(lines[0]),
      .lineState(lineState), .rxActive(rxActive), .rxError(rxError), .rxPktStart(pktStart),
      .rxPidValid(pktStart), .rxPid(pid), .rxTokenValid(tokValid), .rxTokenAddr(tokAddr),
      .rxTokenEndp(tokEndp), .rxCrc5Ok(tokGood), .rxPidOk(tokGood), .rxCrc16Fail(crc16Fail),
      .rxFrameValid(frmValid), .rxFrameNum(frmNum), .rxEndpoint(rxEp), .rxEndpointValid(rxEpValid),
      .flagOutPortA(ports[0]), .flagOutPortB(ports[1]), .flagOutPortC(ports[2]), .flagOutPortD(ports[3]));
   uir_xcvr_model mdl (.clk(clk), .otgSt(otgSt), .lines(lines), .lineState(lineState), .rxActive(rxActive),
      .rxError(rxError), .pktStart(pktStart), .crc16Fail(crc16Fail), .frmValid(frmValid), .frmNum(frmNum),
      .tokValid(tokValid), .pid(pid), .tokAddr(tokAddr), .tokEndp(tokEndp), .tokGood(tokGood));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle write strobe; returns once the write has landed
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask
   // answer is fixed at the taking edge and checked just after it
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      `CHK("read valid", 1'b1, regRdValid)
      `CHK("read data", ex, regRdData)
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset;
      `CHK("modes", 5'h07, {opMode, modeBits})
      `CHK("otg outs", 7'h00, otgOut)
      `CHK("serial outs", 4'h2, serOut)
      for (int a = 'h0c; a <= 'h38; a += 4) rd(8'(a), (a == 'h0c) ? 32'h7 : (a == 'h18) ? 32'h2 : 32'h0);
      rd(8'hfc, 32'h0000_0000);
   endtask
   task automatic t_ctrl;
      wr(ADDR_FUNC_CTRL, 32'h0000_0000);
      `CHK("modes off", 5'h00, {opMode, modeBits})
      wr(ADDR_FUNC_CTRL, 32'hffff_fffe);
      `CHK("modes on", 5'h1e, {opMode, modeBits})
      rd(ADDR_FUNC_CTRL, 32'h0000_001e);
      wr(ADDR_OTG_CTRL, 32'hffff_ffff);
      `CHK("otg all", 7'h7f, otgOut)
      rd(ADDR_OTG_CTRL, 32'h0000_00df);
      wr(ADDR_OTG_CTRL, 32'h0000_0041);
      `CHK("otg drive", 7'h21, otgOut)
      mdl.set_st(6'h2a, 3'h5, 2'h3, 1'b0, 1'b0);
      wr(ADDR_SERIAL, 32'hffff_ffff);
      `CHK("serial on", 4'hf, serOut)
      rd(ADDR_SERIAL, 32'h0000_005f);
      rd(ADDR_OTG_FLAGS, 32'h0000_002a);
      wr(ADDR_SERIAL, 32'h0000_0001);
      `CHK("tx enabled", 4'h1, serOut)
      wr(ADDR_LAST_PID, 32'h0000_000f);
      rd(ADDR_LAST_PID, 32'h0000_0000);
   endtask
   // each line state code in turn, with rx active and rx error varied
   task automatic t_lines;
      logic [31:0] ex;
      wr(ADDR_PORT_MASKS, 32'h0220_0440);
      for (int i = 0; i < 3; i++) begin
         mdl.set_st(6'h00, 3'h0, 2'(i), i[0], i[1]);
         cyc(1);
         ex = {25'h0, 1'b0, i == 0, i == 2, i == 1, 1'b0, i[0], i[1]};
         `CHK("port c", i == 0, ports[2])
         `CHK("port d", i[0], ports[3])
         rd(ADDR_LINE_FLAGS, ex);
      end
      mdl.set_st(6'h00, 3'h0, 2'h3, 1'b0, 1'b0);
   endtask
   task automatic t_token;
      wr(ADDR_DEV_ADDR, 32'h0000_0005);
      wr(ADDR_EP_MARK, 32'h0000_0008);
      mdl.token(4'h9, 7'h05, 4'h3, 1'b1);
      #1;
      `CHK("marked ep", 6'h33, {rxEpValid, rxEp})
      cyc(1);
      `CHK("token port", 1'b1, ports[0])
      rd(ADDR_LAST_PID, 32'h0000_0009);
      rd(ADDR_LAST_EP, 32'h0000_0013);
      mdl.token(4'h1, 7'h05, 4'h5, 1'b1);
      #1;
      `CHK("plain ep", 6'h25, {rxEpValid, rxEp})
      mdl.token(4'h1, 7'h05, 4'h6, 1'b0);
      #1;
      `CHK("bad token", 1'b0, rxEpValid)
      mdl.token(4'h1, 7'h06, 4'h7, 1'b1);
      #1;
      `CHK("other addr", 1'b0, rxEpValid)
      rd(ADDR_LAST_EP, 32'h0000_0015);
      mdl.pulse(3'h4, 11'h00b);
      cyc(1);
      `CHK("token flag cleared", 1'b0, ports[0])
      rd(ADDR_LAST_PID, 32'h0000_000b);
   endtask
   task automatic t_sticky;
      wr(ADDR_STICKY, 32'h0000_0004);
      mdl.pulse(3'h2, 11'h000);
      cyc(1);
      `CHK("crc port", 1'b1, ports[1])
      mdl.pulse(3'h4, 11'h000);
      cyc(1);
      `CHK("sticky hold", 1'b1, ports[1])
      wr(ADDR_LINE_FLAGS, 32'h0000_0004);
      cyc(1);
      `CHK("sticky cleared", 1'b0, ports[1])
   endtask
   // hardware load, then software overwrite with reserved bits set
   task automatic t_frame;
      mdl.pulse(3'h1, 11'h7ff);
      rd(ADDR_FRAME, 32'h0000_07ff);
      wr(ADDR_FRAME, 32'hffff_f123);
      rd(ADDR_FRAME, 32'h0000_0123);
   endtask
   // soft reset needs an idle edge before the next request
   task automatic t_soft;
      wr(ADDR_SOFT_RESET, 32'h0000_0000);
      cyc(2);
      `CHK("soft modes", 5'h07, {opMode, modeBits})
      rd(ADDR_STICKY, 32'h0000_0000);
   endtask
   initial begin
      {sys_rst, regWrite, regRead, regAddr, regWrData} = {3'h4, 8'h00, 32'h0000_0000};
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset;
      t_ctrl;
      t_lines;
      t_token;
      t_sticky;
      t_frame;
      t_soft;
      give_verdict;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict;
   end
endmodule
`default_nettype wire
